// file: design/smrc_pkg.sv
// Shared constants of the ADC input routing control block.
// Assumes a 32-bit AXI4-Lite register bus.
package smrc_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] SMPL_OFS      = 8'h04;
  localparam logic [7:0] FW_SW_OFS     = 8'h08;
  localparam logic [7:0] HW_OWN_OFS    = 8'h0c;
  localparam logic [7:0] SW_STAT_OFS   = 8'h10;
  localparam logic [7:0] RES_STAT_OFS  = 8'h14;
  localparam logic [7:0] CHAN_CFG_OFS  = 8'h40;
  // Control register fields
  localparam int REF_SEL_LSB     = 4;
  localparam int MINUS_SEL_LSB   = 9;
  localparam int MINUS_REF_BIT   = 13;
  localparam int SW_DISABLE_BIT  = 30;
  // Sample control fields
  localparam int ALT_RES_BIT     = 0;
  localparam int ALIGN_BIT       = 1;
  localparam int SIGNED_LSB      = 2;
  localparam int AVG_CNT_LSB     = 4;
  // Channel configuration fields
  localparam int PIN_LSB         = 0;
  localparam int PORT_LSB        = 4;
  localparam int DIFF_BIT        = 8;
  localparam int RES_BIT         = 9;
  localparam int AVG_BIT         = 10;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SMPL_RST = 32'h0000_0000;
  localparam logic [29:0] SW_RST   = 30'h0000_0000;
  localparam logic [15:0] CFG_RST  = 16'h0000;
  // Switch map: 0..7 pin to plus, 8..15 pin to minus, then the rest
  localparam int SW_TEMP_POS   = 16;
  localparam int SW_SBA_POS    = 17;
  localparam int SW_SBB_POS    = 18;
  localparam int SW_AMPA_POS   = 19;
  localparam int SW_AMPB_NEG   = 20;
  localparam int SW_VSSA_NEG   = 21;
  localparam int SW_SBB_NEG    = 22;
  localparam int SW_FW_REF_NEG = 23;
  localparam int SW_NEG_BASE   = 8;
  // Port and pin addresses
  localparam logic [2:0] PORT_PINS = 3'h0;
  localparam logic [2:0] PORT_AMP  = 3'h1;
  localparam logic [2:0] PORT_INT  = 3'h7;
  localparam logic [2:0] PIN_TEMP  = 3'h0;
  localparam logic [2:0] PIN_SBA   = 3'h2;
  localparam logic [2:0] PIN_SBB   = 3'h3;
  // Minus input selection codes (single-ended)
  localparam logic [2:0] MSEL_VSSA = 3'h0;
  localparam logic [2:0] MSEL_VREF = 3'h6;
  localparam logic [2:0] MSEL_NONE = 3'h7;
  // Effective resolution codes
  localparam logic [1:0] RES_12    = 2'h0;
  localparam logic [1:0] RES_10    = 2'h1;
  localparam logic [1:0] RES_8     = 2'h2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: design/smrc_top.sv
// Routing switch control and global conversion settings of the ADC.
// Assumes an external scan sequencer giving the active channel index,
// and an analog switch matrix driven by the switch outputs.
`timescale 1ns/1ps

// Behaviour
// R1: Sequencer controls switch only with both bits; sw_ref_minus follows it on MINUS_REF_BIT alone
// R2: Disable bit blocks all sequencer closing
// R3: Firmware bits close regardless of disable
// R4: Port [6:4] and pin [2:0] select input
// R5: Port 0 picks one of eight pins
// R6: Port 7: temp pin0, bus A 2, B 3
// R7: Port 1: amp bus a plus, b diff minus
// R8: Differential ignores pin bit 0, pairs derived
// R9: Valid pairs 0/1, 2/3, 4/5, 6/7
// R10: Minus select used only single-ended
// R11: Software programs minus select single-ended
// R12: Reference to minus needs separate control bit
// R13: Reset leaves firmware control, bits independent
// R14: Owner bit set hands switch to sequencer
// R15: Software should set disable in firmware mode
// R16: Firmware mode ignores minus select field
// R17: Software leaves in-use settings unchanged mid-scan
// R18: Global reference, format, averaging fields held
// R19: Alternate resolution only where channel enables
// R20: Switch output combines firmware and sequencer
module smrc_top
  import smrc_pkg::*;
#(
  parameter int NCHAN = 8,
  parameter int CW    = 3
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic             seq_active,
  input  wire logic [CW-1:0]    seq_chan,
  output logic [29:0]           switch_out,
  output logic                  sw_ref_minus,
  output logic [2:0]            ref_sel,
  output logic [1:0]            signed_fmt,
  output logic                  left_align,
  output logic [3:0]            avg_count,
  output logic [1:0]            chan_res,
  output logic                  chan_avg
);
  logic [31:0] ctrl_r;
  logic [31:0] smpl_r;
  logic [29:0] fw_switch_bits_r;
  logic [29:0] switch_hw_owner_r;
  logic [15:0] cfg_r [NCHAN];
  logic [29:0] sw_r;
  logic        ref_r;
  logic [1:0]  res_r;
  logic        avg_r;
  logic [7:0]  awaddr_r;
  logic        aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        w_have_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // Bus write path
  wire        aw_take   = s_axi_awvalid && !aw_have_r;
  wire        w_take    = s_axi_wvalid && !w_have_r;
  wire [7:0]  wa        = aw_have_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd        = w_have_r ? wdata_r : s_axi_wdata;
  wire [3:0]  ws        = w_have_r ? wstrb_r : s_axi_wstrb;
  wire        aw_ok     = aw_have_r || s_axi_awvalid;
  wire        w_ok      = w_have_r || s_axi_wvalid;
  wire        wr_go     = aw_ok && w_ok && !bvalid_r;
  wire        wa_cfg    = wa >= CHAN_CFG_OFS && wa < CHAN_CFG_OFS + 8'(4 * NCHAN);
  wire [7:0]  wa_idx    = (wa - CHAN_CFG_OFS) >> 2;
  wire        wa_hit    = wa == CTRL_OFS || wa == SMPL_OFS || wa == FW_SW_OFS
                          || wa == HW_OWN_OFS || wa == SW_STAT_OFS
                          || wa == RES_STAT_OFS || wa_cfg;
  wire [31:0] wmask     = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wa_hit ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_have_r <= 1'b1;
          awaddr_r  <= s_axi_awaddr;
        end
        if (w_take) begin
          w_have_r <= 1'b1;
          wdata_r  <= s_axi_wdata;
          wstrb_r  <= s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end

  // Registers; reset leaves every switch under firmware ownership
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r            <= CTRL_RST;
      smpl_r            <= SMPL_RST;
      fw_switch_bits_r  <= SW_RST;
      switch_hw_owner_r <= SW_RST; // R13
    end else if (wr_go) begin
      if (wa == CTRL_OFS) begin
        ctrl_r <= merge(ctrl_r, wd, wmask); // R18
      end
      if (wa == SMPL_OFS) begin
        smpl_r <= merge(smpl_r, wd, wmask); // R18
      end
      if (wa == FW_SW_OFS) begin
        fw_switch_bits_r <= 30'(merge({2'b00, fw_switch_bits_r}, wd, wmask));
      end
      if (wa == HW_OWN_OFS) begin
        switch_hw_owner_r <= 30'(merge({2'b00, switch_hw_owner_r}, wd, wmask));
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCHAN; gi++) begin : g_cfg
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cfg_r[gi] <= CFG_RST;
        end else if (wr_go && wa_cfg && wa_idx == 8'(gi)) begin
          cfg_r[gi] <= 16'(merge({16'h0000, cfg_r[gi]}, wd, wmask));
        end
      end
    end
  endgenerate

  // Bus read path
  wire        ar_go   = s_axi_arvalid && !rvalid_r;
  wire        ra_cfg  = s_axi_araddr >= CHAN_CFG_OFS
                        && s_axi_araddr < CHAN_CFG_OFS + 8'(4 * NCHAN);
  wire [7:0]  ra_idx  = (s_axi_araddr - CHAN_CFG_OFS) >> 2;
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      CTRL_OFS:     rd_val = ctrl_r;
      SMPL_OFS:     rd_val = smpl_r;
      FW_SW_OFS:    rd_val = {2'b00, fw_switch_bits_r};
      HW_OWN_OFS:   rd_val = {2'b00, switch_hw_owner_r};
      SW_STAT_OFS:  rd_val = {1'b0, ref_r, sw_r};
      RES_STAT_OFS: rd_val = {29'h0, avg_r, res_r};
      default: begin
        rd_val = ra_cfg ? {16'h0000, cfg_r[CW'(ra_idx)]} : 32'h0000_0000;
        rd_hit = ra_cfg;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (ar_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Active channel decode
  wire [15:0] act_cfg   = cfg_r[seq_chan];
  wire [2:0]  pin       = act_cfg[PIN_LSB +: 3]; // R4
  wire [2:0]  port      = act_cfg[PORT_LSB +: 3]; // R4
  wire        diff      = act_cfg[DIFF_BIT];
  wire        seq_ok    = seq_active && !ctrl_r[SW_DISABLE_BIT]; // R2
  wire [2:0]  msel      = ctrl_r[MINUS_SEL_LSB +: 3];
  wire [2:0]  pos_pin   = diff ? {pin[2:1], 1'b0} : pin; // R8 R9
  wire [2:0]  neg_pin   = {pin[2:1], 1'b1}; // R8 R9
  wire        is_pins   = port == PORT_PINS;
  wire        is_amp    = port == PORT_AMP;
  wire        is_int    = port == PORT_INT;
  wire        se_neg    = !diff && (is_pins || is_amp || is_int);

  logic [29:0] seq_sel;
  always_comb begin
    seq_sel = 30'h0000_0000;
    if (is_pins) begin
      seq_sel[pos_pin] = 1'b1; // R5
      if (diff) begin
        seq_sel[SW_NEG_BASE + 32'(neg_pin)] = 1'b1; // R8
      end
    end
    if (is_amp) begin
      seq_sel[SW_AMPA_POS] = 1'b1; // R7
      seq_sel[SW_AMPB_NEG] = diff; // R7
    end
    if (is_int) begin
      seq_sel[SW_TEMP_POS] = pos_pin == PIN_TEMP; // R6
      seq_sel[SW_SBA_POS]  = pos_pin == PIN_SBA; // R6
      seq_sel[SW_SBB_POS]  = pin == PIN_SBB && !diff; // R6
      seq_sel[SW_SBB_NEG]  = diff && pos_pin == PIN_SBA; // R8
    end
    if (se_neg) begin
      seq_sel[SW_VSSA_NEG] = msel == MSEL_VSSA; // R10
      if (msel != MSEL_VSSA && msel < MSEL_VREF) begin
        seq_sel[SW_NEG_BASE + 32'({msel - 3'h1, 1'b1})] = 1'b1; // R10
      end
    end
  end

  // Owned switches follow the sequencer gated by their firmware bit
  wire [29:0] seq_term = fw_switch_bits_r & seq_sel & {30{seq_ok}}; // R1 R20
  wire [29:0] sw_nxt   = (switch_hw_owner_r & seq_term)
                         | (~switch_hw_owner_r & fw_switch_bits_r); // R3 R14 R20
  wire        ref_seq  = seq_ok && se_neg && msel == MSEL_VREF;
  wire        ref_nxt  = ctrl_r[MINUS_REF_BIT] ? ref_seq
                         : fw_switch_bits_r[SW_FW_REF_NEG]; // R12 R16
  wire        avg_en   = act_cfg[AVG_BIT];
  wire [1:0]  res_nxt  = (avg_en || !act_cfg[RES_BIT]) ? RES_12
                         : (smpl_r[ALT_RES_BIT] ? RES_10 : RES_8); // R19

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_r  <= SW_RST;
      ref_r <= 1'b0;
      res_r <= RES_12;
      avg_r <= 1'b0;
    end else begin
      sw_r  <= sw_nxt;
      ref_r <= ref_nxt;
      res_r <= res_nxt;
      avg_r <= avg_en;
    end
  end

  assign s_axi_awready = aw_take;
  assign s_axi_wready  = w_take;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ar_go;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign switch_out    = sw_r;
  assign sw_ref_minus  = ref_r;
  assign ref_sel       = ctrl_r[REF_SEL_LSB +: 3]; // R18
  assign signed_fmt    = smpl_r[SIGNED_LSB +: 2]; // R18
  assign left_align    = smpl_r[ALIGN_BIT];
  assign avg_count     = smpl_r[AVG_CNT_LSB +: 4]; // R18
  assign chan_res      = res_r;
  assign chan_avg      = avg_r;

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence pins_owned_s;
    seq_ok && is_pins && &(fw_switch_bits_r[15:0] & switch_hw_owner_r[15:0]);
  endsequence

  fw_mode_a: assert property ((switch_hw_owner_r == 30'h0) // R13
    |=> sw_r == $past(fw_switch_bits_r)) else $error("firmware mode mismatch");
  both_bits_a: assert property (1'b1 |=> // R1
    (sw_r & $past(switch_hw_owner_r & ~fw_switch_bits_r)) == 30'h0)
    else $error("owned switch closed without firmware bit");
  seq_off_a: assert property (ctrl_r[SW_DISABLE_BIT] |=> // R2
    (sw_r & $past(switch_hw_owner_r)) == 30'h0) else $error("disable ignored");
  fw_close_a: assert property (1'b1 |=> // R3
    (($past(fw_switch_bits_r & ~switch_hw_owner_r) & ~sw_r) == 30'h0))
    else $error("firmware bit did not close");
  pin_sel_a: assert property (pins_owned_s and !diff |=> sw_r[$past(pin)]) // R5
    else $error("pin not selected");
  diff_pair_a: assert property (pins_owned_s and diff |=> // R8
    sw_r[{$past(pin[2:1]), 1'b0}] && sw_r[SW_NEG_BASE + {$past(pin[2:1]), 1'b1}]
    && !(sw_r[SW_VSSA_NEG] && $past(switch_hw_owner_r[SW_VSSA_NEG])))
    else $error("differential pair wrong");
  amp_bus_a: assert property (seq_ok && is_amp && fw_switch_bits_r[SW_AMPA_POS] // R7
    && switch_hw_owner_r[SW_AMPA_POS] |=> sw_r[SW_AMPA_POS])
    else $error("amp bus not routed");
  temp_sel_a: assert property (seq_ok && is_int && pin == PIN_TEMP && !diff // R6
    && fw_switch_bits_r[SW_TEMP_POS] && switch_hw_owner_r[SW_TEMP_POS]
    |=> sw_r[SW_TEMP_POS]) else $error("temperature not routed");
  ref_minus_a: assert property (!ctrl_r[MINUS_REF_BIT] |=> // R12
    sw_ref_minus == $past(fw_switch_bits_r[SW_FW_REF_NEG]))
    else $error("reference switch not firmware driven");
  res_sel_a: assert property (!act_cfg[RES_BIT] || act_cfg[AVG_BIT] // R19
    |=> chan_res == RES_12) else $error("resolution not 12 bits");

  // Differential conversions must not take the minus select
  sequence diff_seq_s;
    seq_ok && diff && switch_hw_owner_r[SW_VSSA_NEG];
  endsequence

  minus_ignore_a: assert property (diff_seq_s |=> !sw_r[SW_VSSA_NEG]) // R10
    else $error("minus select used in differential mode");
  amp_single_a: assert property (seq_ok && is_amp && !diff // R7
    && switch_hw_owner_r[SW_AMPB_NEG] |=> !sw_r[SW_AMPB_NEG])
    else $error("amp bus b closed single-ended");
  pair_even_a: assert property (pins_owned_s and diff |=> // R9
    !sw_r[{$past(pin[2:1]), 1'b1}]) else $error("odd pin routed to plus");
  seq_ref_off_a: assert property (ctrl_r[MINUS_REF_BIT] && ctrl_r[SW_DISABLE_BIT] // R2
    |=> !sw_ref_minus) else $error("disabled sequencer closed reference");
endmodule

// file: verification/smrc_matrix_model.sv
// Behavioural model of the analog switch matrix in front of the ADC inputs.
// Assumes the switch map of the routing control package; counts closed paths.
`timescale 1ns/1ps
module smrc_matrix_model
  import smrc_pkg::*;
(
  input  wire logic [29:0] switch_out,
  input  wire logic        sw_ref_minus,
  output logic [4:0]       plus_cnt,
  output logic [4:0]       minus_cnt
);
  logic [29:0] plus_mask;
  // Plus side: pins, temperature, both shared buses, amplifier bus a
  assign plus_mask = 30'h000f_00ff;
  // Several plus paths closed at once would short sources together
  assign plus_cnt  = 5'($countones(switch_out & plus_mask));
  assign minus_cnt = 5'($countones(switch_out & 30'h0070_ff00)) + 5'(sw_ref_minus);
endmodule

// file: verification/testbench.sv
// Self-checking bench of the routing control block over AXI4-Lite.
// Assumes the register map and switch map of the routing control package.
`timescale 1ns/1ps
module testbench
  import smrc_pkg::*;
;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, signed_fmt, chan_res;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, seq_active, sw_ref_minus, left_align, chan_avg;
  logic [2:0]  seq_chan, ref_sel;
  logic [29:0] switch_out;
  logic [3:0]  avg_count;
  logic [4:0]  plus_cnt, minus_cnt;
  int          error_cnt, n_tests, cyc;
  logic [31:0] rd_v;
  // Routing cases: channel config, minus select, expected switches
  logic [15:0] tc_cfg [0:10] = '{16'h0005, 16'h0005, 16'h0070, 16'h0072, 16'h0073,
    16'h0071, 16'h0020, 16'h0016, 16'h0110, 16'h0103, 16'h0104};
  logic [2:0]  tc_ms [0:10] = '{3'h0, 3'h2, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7,
    3'h0, 3'h0, 3'h0};
  logic [29:0] tc_sw [0:10] = '{30'h0020_0020, 30'h0000_0820, 30'h0001_0000,
    30'h0002_0000, 30'h0004_0000, 30'h0, 30'h0, 30'h0008_0000, 30'h0018_0000,
    30'h0000_0804, 30'h0000_2010};
  smrc_top smrc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .seq_active(seq_active), .seq_chan(seq_chan),
    .switch_out(switch_out), .sw_ref_minus(sw_ref_minus), .ref_sel(ref_sel),
    .signed_fmt(signed_fmt), .left_align(left_align), .avg_count(avg_count),
    .chan_res(chan_res), .chan_avg(chan_avg));
  smrc_matrix_model smrc_matrix_model_inst (.switch_out(switch_out),
    .sw_ref_minus(sw_ref_minus), .plus_cnt(plus_cnt), .minus_cnt(minus_cnt));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd, ah, wh;
    logic [1:0] rsp;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ah) begin s_axi_awvalid <= 1'b0; ad = 1'b1; end
      if (wh) begin s_axi_wvalid <= 1'b0; wd = 1'b1; end
    end
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ah  = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
    end while (!ah);
    s_axi_bready <= 1'b0;
    chk(32'(rsp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    logic h;
    logic [1:0] rsp;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      h = s_axi_arready;
      @(posedge aclk);
    end while (!h);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge aclk);
      h    = s_axi_rvalid;
      rd_v = s_axi_rdata;
      rsp  = s_axi_rresp;
      @(posedge aclk);
    end while (!h);
    s_axi_rready <= 1'b0;
    chk(32'(rsp), 32'(er));
  endtask
  task automatic settle();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic ctrl_cfg(input logic [31:0] c, input logic [15:0] cfg);
    logic s;
    @(posedge aclk);
    s = seq_active;
    seq_active <= 1'b0;
    wr(CHAN_CFG_OFS + 8'h0c, 32'(cfg), RESP_OKAY);
    wr(CTRL_OFS, c, RESP_OKAY);
    seq_active <= s;
    settle();
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, seq_active, seq_chan, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(32'(switch_out), 32'h0);
    chk(32'(chan_res), 32'(RES_12));
    rd(CTRL_OFS, RESP_OKAY);
    chk(rd_v, CTRL_RST);
    $display("test reset done");
    wr(FW_SW_OFS, 32'h2aaa_5555, RESP_OKAY);
    ctrl_cfg(32'h4000_0e00, 16'h0005);
    chk(32'(switch_out), 32'h2aaa_5555);
    rd(SW_STAT_OFS, RESP_OKAY);
    chk(rd_v, 32'h6aaa_5555);
    $display("test firmware done");
    wr(FW_SW_OFS, 32'h3f7f_ffff, RESP_OKAY);
    wr(HW_OWN_OFS, 32'h3fff_ffff, RESP_OKAY);
    wr(CHAN_CFG_OFS, 32'h0070, RESP_OKAY);
    seq_chan   <= 3'h3;
    seq_active <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      ctrl_cfg(32'(tc_ms[i]) << MINUS_SEL_LSB, tc_cfg[i]);
      chk(32'(switch_out), 32'(tc_sw[i]));
      chk(32'(plus_cnt), 32'($countones(tc_sw[i] & 30'h000f_00ff)));
      chk(32'(minus_cnt), 32'($countones(tc_sw[i] & 30'h0070_ff00)));
    end
    $display("test sequencer done");
    ctrl_cfg(32'h4000_0000, 16'h0005);
    chk(32'(switch_out), 32'h0);
    wr(FW_SW_OFS, 32'h3f7f_ffdf, RESP_OKAY);
    ctrl_cfg(32'h0, 16'h0005);
    chk(32'(switch_out), 32'h0020_0000);
    wr(FW_SW_OFS, 32'h3f7f_ffff, RESP_OKAY);
    wr(HW_OWN_OFS, 32'h3fff_ffdf, RESP_OKAY);
    ctrl_cfg(32'h0, 16'h0070);
    chk(32'(switch_out), 32'h0021_0020);
    ctrl_cfg(32'h4000_0000, 16'h0070);
    chk(32'(switch_out), 32'h0000_0020);
    ctrl_cfg(32'h0000_0c00, 16'h0005);
    chk(32'(sw_ref_minus), 32'h0);
    ctrl_cfg(32'h0000_2c00, 16'h0005);
    chk(32'(sw_ref_minus), 32'h1);
    ctrl_cfg(32'h4000_2c00, 16'h0005);
    chk(32'(sw_ref_minus), 32'h0);
    $display("test ownership done");
    wr(SMPL_OFS, 32'h0000_009b, RESP_OKAY);
    ctrl_cfg(32'h0000_0030, 16'h0205);
    chk(32'(ref_sel), 32'h3);
    chk(32'(signed_fmt), 32'h2);
    chk(32'(avg_count), 32'h9);
    chk(32'(left_align), 32'h1);
    chk(32'(chan_res), 32'(RES_10));
    wr(SMPL_OFS, 32'h0000_0098, RESP_OKAY);
    settle();
    chk(32'(chan_res), 32'(RES_8));
    chk(32'(left_align), 32'h0);
    ctrl_cfg(32'h0000_0030, 16'h0605);
    chk(32'(chan_res), 32'(RES_12));
    chk(32'(chan_avg), 32'h1);
    rd(RES_STAT_OFS, RESP_OKAY);
    chk(rd_v, 32'({1'b1, RES_12}));
    ctrl_cfg(32'h0000_0030, 16'h0005);
    chk(32'(chan_res), 32'(RES_12));
    chk(32'(chan_avg), 32'h0);
    $display("test globals done");
    wr(8'h30, 32'hffff_ffff, RESP_SLVERR);
    rd(8'h30, RESP_SLVERR);
    chk(rd_v, 32'h0);
    $display("test unmapped done");
    summarize();
  end
endmodule
